// ==== hdl/eblane_pkg.sv ====
// Constants and types shared by the byte-lane and address output logic
package eblane_pkg;
	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int DATA_W  = 32;  // Data path width
	localparam int LANES   = 4;   // Byte lanes on the data path
	localparam int LANE_W  = 8;   // Bits per lane
	localparam int BADDR_W = 32;  // Byte address width from the core
	localparam int WADDR_W = 34;  // Word address bits 35:2
	localparam int WADDR_LO = 2;  // Lowest address bit on the bus
	localparam int HIGH_ZERO_W = 4; // Uppermost bits 35:32, held at zero
	localparam int OFS_W   = 2;   // Byte offset inside a word

	// ==========================================================================
	// Access sizes
	// ==========================================================================
	typedef enum logic [1:0] {
		EBLANE_SZ_BYTE = 2'h0,  // One lane
		EBLANE_SZ_HALF = 2'h1,  // Two lanes
		EBLANE_SZ_WORD = 2'h2,  // Four lanes
		EBLANE_SZ_RSV  = 2'h3   // Treated as word
	} eblane_size_e;

	// ==========================================================================
	// Sequencer states
	// ==========================================================================
	typedef enum logic [1:0] {
		EBLANE_ST_IDLE = 2'h0,  // Ready for a request
		EBLANE_ST_ADDR = 2'h1,  // Address phase, strobe up
		EBLANE_ST_RD   = 2'h2,  // Waiting for read data
		EBLANE_ST_WR   = 2'h3   // Waiting for write data acceptance
	} eblane_state_e;

	// ==========================================================================
	// Lane masks and reset values
	// ==========================================================================
	localparam logic [LANES-1:0]   LANES_NONE = 4'h0;  // No lane enabled
	localparam logic [LANES-1:0]   LANES_ONE  = 4'h1;  // Byte mask at lane 0
	localparam logic [LANES-1:0]   LANES_TWO  = 4'h3;  // Half mask at lane 0
	localparam logic [LANES-1:0]   LANES_ALL  = 4'hf;  // Whole word
	localparam logic [DATA_W-1:0]  DATA_ZERO  = 32'h0; // Cleared data
	localparam logic [WADDR_W-1:0] WADDR_ZERO = 34'h0; // Cleared address
	localparam logic [HIGH_ZERO_W-1:0] HIGH_ZERO = 4'h0; // Upper address bits
	localparam logic [OFS_W-1:0]   OFS_ZERO   = 2'h0;  // Offset zero
endpackage : eblane_pkg

// ==== hdl/eblane_rd_if.sv ====
// Carrier between the sequencer and the read lane merger
`timescale 1ns/1ps
`default_nettype none
interface eblane_rd_if;
	logic [eblane_pkg::DATA_W-1:0] bus_data;  // Raw read data bus
	logic                          bus_valid; // Read data valid this cycle
	logic                          take;      // Sequencer is waiting for data
	logic [eblane_pkg::LANES-1:0]  lanes;     // Enabled lanes of the transfer
	logic [eblane_pkg::OFS_W-1:0]  offset;    // Byte offset of the access

	// Sequencer side
	modport seq (output bus_data, output bus_valid, output take, output lanes, output offset);
	// Merger side
	modport mrg (input bus_data, input bus_valid, input take, input lanes, input offset);
endinterface : eblane_rd_if
`default_nettype wire

// ==== hdl/eblane_rd_merge.sv ====
// Read lane merger: keeps enabled lanes only and aligns them to bit 0
`timescale 1ns/1ps
`default_nettype none
module eblane_rd_merge (
	input  wire logic                          clk,
	input  wire logic                          rst,
	eblane_rd_if.mrg                           rd,
	output logic                               rsp_valid,
	output logic [eblane_pkg::DATA_W-1:0]      rsp_rdata
);
	// ==========================================================================
	// Lane masking
	// ==========================================================================
	logic [eblane_pkg::DATA_W-1:0] masked;  // Disabled lanes forced to zero
	logic [eblane_pkg::DATA_W-1:0] aligned; // Shifted down by the offset

	genvar g;
	generate
		for (g = 0; g < eblane_pkg::LANES; g++) begin : g_lane
			// Lane g covers bits 8g+7 down to 8g
			assign masked[g*eblane_pkg::LANE_W +: eblane_pkg::LANE_W] =
				rd.lanes[g] ? rd.bus_data[g*eblane_pkg::LANE_W +: eblane_pkg::LANE_W] // RQ3
				            : 8'h00; // RQ6
		end
	endgenerate

	// Move the first enabled byte down to bit 0
	assign aligned = masked >> {rd.offset, 3'h0};

	// ==========================================================================
	// Registered answer
	// ==========================================================================
	// Valid pulse for one cycle when data is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= rd.take & rd.bus_valid; // RQ6
		end
	end

	// Data holds until the next read completes
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_rdata <= eblane_pkg::DATA_ZERO;
		end else if (rd.take & rd.bus_valid) begin
			rsp_rdata <= aligned;
		end
	end
endmodule : eblane_rd_merge
`default_nettype wire

// ==== hdl/eblane_top.sv ====
// Byte-lane and address output sequencer of the external bus interface
//
// Operation
// [RQ1] Enable exactly the lanes the transfer touches
// [RQ2] Lane enables meaningful only with address valid
// [RQ3] Lane n maps to data bits 8n+7:8n
// [RQ4] Word address 35:2, upper four bits zero
// [RQ5] Write indicator marks writes during address valid
// [RQ6] Target flags read data; sample enabled lanes
// [RQ7] Target updates only enabled lanes on writes
`timescale 1ns/1ps
`default_nettype none
module eblane_top (
	input  wire logic                                clk,
	input  wire logic                                rst,
	// Core request side
	input  wire logic                                req_valid,
	input  wire logic                                req_write,
	input  wire logic [eblane_pkg::BADDR_W-1:0]      req_addr,
	input  wire logic [1:0]                          req_size,
	input  wire logic [eblane_pkg::DATA_W-1:0]       req_wdata,
	output logic                                     req_ready,
	output logic                                     rsp_valid,
	output logic [eblane_pkg::DATA_W-1:0]            rsp_rdata,
	output logic                                     wr_done,
	// System bus side
	output logic                                     address_valid_strobe,
	input  wire logic                                address_ready,
	output logic [eblane_pkg::WADDR_W-1:0]           bus_word_address,
	output logic [eblane_pkg::LANES-1:0]             byte_lane_enable,
	output logic                                     write_indicator,
	output logic [eblane_pkg::DATA_W-1:0]            write_data_bus,
	input  wire logic                                write_data_ready,
	input  wire logic [eblane_pkg::DATA_W-1:0]       read_data_bus,
	input  wire logic                                read_data_valid
);
	// ==========================================================================
	// Lane decode
	// ==========================================================================
	// Lanes touched by an access of the given size at the given offset
	function automatic logic [eblane_pkg::LANES-1:0] lane_mask(
		input logic [1:0]                 size,
		input logic [eblane_pkg::OFS_W-1:0] ofs
	);
		logic [eblane_pkg::LANES-1:0] m;
		m = eblane_pkg::LANES_ALL;
		case (size)
			eblane_pkg::EBLANE_SZ_BYTE: begin
				m = eblane_pkg::LANES_ONE << ofs;
			end
			eblane_pkg::EBLANE_SZ_HALF: begin
				// Halfwords stay inside their aligned half
				m = eblane_pkg::LANES_TWO << {ofs[1], 1'b0};
			end
			default: begin
				m = eblane_pkg::LANES_ALL;
			end
		endcase
		return m;
	endfunction

	// Effective byte offset after natural alignment
	function automatic logic [eblane_pkg::OFS_W-1:0] lane_ofs(
		input logic [1:0]                 size,
		input logic [eblane_pkg::OFS_W-1:0] ofs
	);
		logic [eblane_pkg::OFS_W-1:0] o;
		o = eblane_pkg::OFS_ZERO;
		case (size)
			eblane_pkg::EBLANE_SZ_BYTE: begin
				o = ofs;
			end
			eblane_pkg::EBLANE_SZ_HALF: begin
				o = {ofs[1], 1'b0};
			end
			default: begin
				o = eblane_pkg::OFS_ZERO;
			end
		endcase
		return o;
	endfunction

	// ==========================================================================
	// State
	// ==========================================================================
	eblane_pkg::eblane_state_e state_reg;  // Sequencer state
	eblane_pkg::eblane_state_e state_next; // Next state
	logic [eblane_pkg::LANES-1:0] lanes_reg; // Lanes of the held transfer
	logic [eblane_pkg::OFS_W-1:0] ofs_reg;   // Offset of the held transfer
	logic                         take;      // Request accepted this cycle
	logic [eblane_pkg::OFS_W-1:0] req_ofs;   // Aligned offset of the request
	logic [eblane_pkg::LANES-1:0] req_lanes; // Lanes of the request

	assign take      = req_valid & req_ready;
	assign req_ofs   = lane_ofs(req_size, req_addr[eblane_pkg::OFS_W-1:0]);
	assign req_lanes = lane_mask(req_size, req_addr[eblane_pkg::OFS_W-1:0]); // RQ1

	// Next state selection
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			eblane_pkg::EBLANE_ST_IDLE: begin
				// Only a request seen with ready up starts a transfer
				if (take) begin
					state_next = eblane_pkg::EBLANE_ST_ADDR;
				end
			end
			eblane_pkg::EBLANE_ST_ADDR: begin
				// Strobe holds until the target takes the address
				if (address_ready) begin
					state_next = write_indicator ? eblane_pkg::EBLANE_ST_WR : eblane_pkg::EBLANE_ST_RD;
				end
			end
			eblane_pkg::EBLANE_ST_RD: begin
				if (read_data_valid) begin
					state_next = eblane_pkg::EBLANE_ST_IDLE; // RQ6
				end
			end
			eblane_pkg::EBLANE_ST_WR: begin
				if (write_data_ready) begin
					state_next = eblane_pkg::EBLANE_ST_IDLE;
				end
			end
			default: begin
				state_next = eblane_pkg::EBLANE_ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= eblane_pkg::EBLANE_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Ready while idle; drops the cycle after a request is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_next == eblane_pkg::EBLANE_ST_IDLE);
		end
	end

	// ==========================================================================
	// Address phase outputs
	// ==========================================================================
	// Strobe up from the cycle after acceptance until address_ready
	always_ff @(posedge clk) begin
		if (rst) begin
			address_valid_strobe <= 1'b0;
		end else begin
			address_valid_strobe <= (state_next == eblane_pkg::EBLANE_ST_ADDR);
		end
	end

	// Lane enables, address and direction loaded with the request
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_lane_enable <= eblane_pkg::LANES_NONE;
			bus_word_address <= eblane_pkg::WADDR_ZERO;
			write_indicator  <= 1'b0;
		end else if (take) begin
			byte_lane_enable <= req_lanes; // RQ1
			bus_word_address <= {eblane_pkg::HIGH_ZERO,
			                     req_addr[eblane_pkg::BADDR_W-1:eblane_pkg::WADDR_LO]}; // RQ4
			write_indicator  <= req_write; // RQ5
		end else if (state_next == eblane_pkg::EBLANE_ST_IDLE) begin
			// Cleared between transfers; meaningless without the strobe
			byte_lane_enable <= eblane_pkg::LANES_NONE; // RQ2
			bus_word_address <= eblane_pkg::WADDR_ZERO;
			write_indicator  <= 1'b0;
		end
	end

	// Transfer shape kept for the read merge
	always_ff @(posedge clk) begin
		if (rst) begin
			lanes_reg <= eblane_pkg::LANES_NONE;
			ofs_reg   <= eblane_pkg::OFS_ZERO;
		end else if (take) begin
			lanes_reg <= req_lanes;
			ofs_reg   <= req_ofs;
		end
	end

	// ==========================================================================
	// Write data
	// ==========================================================================
	logic [eblane_pkg::DATA_W-1:0] wdata_shift; // Core data moved to its byte offset
	logic [eblane_pkg::DATA_W-1:0] wdata_lanes; // Only the enabled lanes kept

	assign wdata_shift = req_wdata << {req_ofs, 3'h0};

	// Lanes outside the transfer are driven as zero, not as stray core bits
	genvar g;
	generate
		for (g = 0; g < eblane_pkg::LANES; g++) begin : g_wlane
			assign wdata_lanes[g*eblane_pkg::LANE_W +: eblane_pkg::LANE_W] =
				req_lanes[g] ? wdata_shift[g*eblane_pkg::LANE_W +: eblane_pkg::LANE_W] // RQ3
				             : 8'h00; // RQ1
		end
	endgenerate

	// Core data placed onto its lanes; other lanes zero
	always_ff @(posedge clk) begin
		if (rst) begin
			write_data_bus <= eblane_pkg::DATA_ZERO;
		end else if (take & req_write) begin
			write_data_bus <= wdata_lanes; // RQ3
		end
	end

	// One-cycle pulse when the target accepts write data
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_done <= 1'b0;
		end else begin
			wr_done <= (state_reg == eblane_pkg::EBLANE_ST_WR) & write_data_ready; // RQ7
		end
	end

	// ==========================================================================
	// Read merge
	// ==========================================================================
	eblane_rd_if rd_link ();

	assign rd_link.bus_data  = read_data_bus;
	assign rd_link.bus_valid = read_data_valid;
	assign rd_link.take      = (state_reg == eblane_pkg::EBLANE_ST_RD);
	assign rd_link.lanes     = lanes_reg; // RQ6
	assign rd_link.offset    = ofs_reg;

	eblane_rd_merge u_merge (
		.clk       (clk),
		.rst       (rst),
		.rd        (rd_link),
		.rsp_valid (rsp_valid),
		.rsp_rdata (rsp_rdata)
	);
endmodule : eblane_top
`default_nettype wire

// ==== tb/eblane_tbx_pkg.sv ====
// Lane and alignment helpers for the bench side
`default_nettype none
package eblane_tbx_pkg;
	// Byte offset after forcing natural alignment
	function automatic logic [1:0] aofs(logic [1:0] sz, logic [1:0] o);
		return (sz == 2'h0) ? o : (sz == 2'h1) ? {o[1], 1'b0} : 2'h0;
	endfunction
	// Right-aligned data mask of an access size
	function automatic logic [31:0] dmask(logic [1:0] sz);
		return (sz == 2'h0) ? 32'hff : (sz == 2'h1) ? 32'hffff : 32'hffffffff;
	endfunction
	// Lanes an access touches
	function automatic logic [3:0] lanes(logic [1:0] sz, logic [1:0] o);
		return ((sz == 2'h0) ? 4'h1 : (sz == 2'h1) ? 4'h3 : 4'hf) << aofs(sz, o);
	endfunction
endpackage : eblane_tbx_pkg
`default_nettype wire

// ==== tb/eblane_top_sva.sv ====
// Assertions on the bus side of the byte-lane sequencer
`timescale 1ns/1ps
`default_nettype none
module eblane_top_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic [31:0] req_addr,
	input wire logic [1:0]  req_size,
	input wire logic [31:0] req_wdata,
	input wire logic        req_ready,
	input wire logic        address_valid_strobe,
	input wire logic        address_ready,
	input wire logic [33:0] bus_word_address,
	input wire logic [3:0]  byte_lane_enable,
	input wire logic        write_indicator,
	input wire logic [31:0] write_data_bus
);
	// ==========================================================================
	// Captured request
	// ==========================================================================
	logic        take;     // Request taken at this edge
	logic [31:0] addr_reg; // Byte address
	logic [1:0]  size_reg; // Access size
	logic        wr_reg;   // Write flag
	logic [31:0] wd_reg;   // Right-aligned write data
	assign take = req_valid && req_ready;
	// Keep the last taken request
	always_ff @(posedge clk) begin
		if (take) begin
			addr_reg <= req_addr;
			size_reg <= req_size;
			wr_reg <= req_write;
			wd_reg <= req_wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================================
	// Properties
	// ==========================================================================
	lane_mask_a: assert property ($rose(address_valid_strobe) |->
		byte_lane_enable == eblane_tbx_pkg::lanes(size_reg, addr_reg[1:0])) else $error("lane enables wrong");
	lane_hold_a: assert property (address_valid_strobe && !address_ready |=>
		address_valid_strobe && $stable(byte_lane_enable)) else $error("lanes moved in address phase");
	strobe_start_a: assert property (take |=> address_valid_strobe && !req_ready)
		else $error("no strobe after request");
	strobe_end_a: assert property (address_valid_strobe && address_ready |=> !address_valid_strobe)
		else $error("strobe stays after accept");
	lane_data_a: assert property ($rose(address_valid_strobe) && write_indicator |-> write_data_bus ==
		(wd_reg & eblane_tbx_pkg::dmask(size_reg)) << (8 * eblane_tbx_pkg::aofs(size_reg, addr_reg[1:0])))
		else $error("write data off its lanes");
	addr_val_a: assert property ($rose(address_valid_strobe) |-> bus_word_address == {4'h0, addr_reg[31:2]})
		else $error("word address wrong");
	addr_top_a: assert property (bus_word_address[33:30] == 4'h0)
		else $error("upper address bits set");
	wr_flag_a: assert property ($rose(address_valid_strobe) |-> write_indicator == wr_reg)
		else $error("write indicator wrong");
	cover property (take && req_write);
	cover property (take && !req_write);
	cover property ($rose(address_valid_strobe) && byte_lane_enable == 4'h8);
endmodule // eblane_top_sva
bind eblane_top eblane_top_sva i_eblane_top_sva (.clk, .rst, .req_valid, .req_write, .req_addr, .req_size,
	.req_wdata, .req_ready, .address_valid_strobe, .address_ready, .bus_word_address, .byte_lane_enable,
	.write_indicator, .write_data_bus);
`default_nettype wire

// ==== tb/eblane_target.sv ====
// Bus target model: word store with lane-wise writes
`timescale 1ns/1ps
`default_nettype none
module eblane_target (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [1:0]  dly,
	input  wire logic        address_valid_strobe,
	input  wire logic [33:0] bus_word_address,
	input  wire logic [3:0]  byte_lane_enable,
	input  wire logic        write_indicator,
	input  wire logic [31:0] write_data_bus,
	output logic             address_ready,
	output logic             write_data_ready,
	output logic [31:0]      read_data_bus,
	output logic             read_data_valid
);
	logic [31:0] mem [16]; // Word store
	logic [3:0]  be_reg;   // Lanes of the accepted address
	logic [3:0]  ix_reg;   // Word index
	logic        wr_reg;   // Accepted transfer is a write
	logic        dat_reg;  // Data phase pending
	logic [1:0]  cnt_reg;  // Wait cycles spent
	// Address phase then data phase, each stretched by dly cycles
	always_ff @(posedge clk) begin
		address_ready <= 1'b0;
		write_data_ready <= 1'b0;
		read_data_valid <= 1'b0;
		read_data_bus <= ~read_data_bus; // Released bus toggles
		if (rst) begin
			dat_reg <= 1'b0;
			cnt_reg <= 2'h0;
			read_data_bus <= 32'h0;
		end else if ((dat_reg || (address_valid_strobe && !address_ready)) && cnt_reg != dly) begin
			cnt_reg <= cnt_reg + 2'h1; // Stall
		end else if (dat_reg) begin
			dat_reg <= 1'b0;
			cnt_reg <= 2'h0;
			if (wr_reg) begin
				write_data_ready <= 1'b1;
				for (int i = 0; i < 4; i++) if (be_reg[i]) mem[ix_reg][8*i+:8] <= write_data_bus[8*i+:8];
			end else begin
				read_data_valid <= 1'b1;
				read_data_bus <= mem[ix_reg];
			end
		end else if (address_valid_strobe && !address_ready) begin
			address_ready <= 1'b1;
			dat_reg <= 1'b1;
			cnt_reg <= 2'h0; // Data phase waits afresh
			be_reg <= byte_lane_enable;
			ix_reg <= bus_word_address[3:0];
			wr_reg <= write_indicator;
		end
	end
endmodule // eblane_target
`default_nettype wire

// ==== tb/eblane_top_bench.sv ====
// Self-checking bench of the byte-lane sequencer
`timescale 1ns/1ps
`default_nettype none
module eblane_top_bench;
	logic        clk = 1'b0;         // Core clock
	logic        rst = 1'b1;         // Sync reset
	logic        req_valid = 1'b0;   // Core request
	logic        req_write = 1'b0;   // Request is a write
	logic [31:0] req_addr = 32'h0;   // Byte address
	logic [1:0]  req_size = 2'h0;    // Access size
	logic [31:0] req_wdata = 32'h0;  // Write data
	logic [1:0]  dly = 2'h0;         // Target wait cycles
	logic        req_ready, rsp_valid, wr_done, address_valid_strobe, address_ready;
	logic        write_indicator, write_data_ready, read_data_valid;
	logic [31:0] rsp_rdata, write_data_bus, read_data_bus;
	logic [33:0] bus_word_address;   // Word address
	logic [3:0]  byte_lane_enable;   // Lane enables
	int          miscompares = 0;    // Mismatches
	int          n_tests = 0;        // Comparisons
	always #2 clk = ~clk;
	eblane_top i_eblane_top (.clk, .rst, .req_valid, .req_write, .req_addr, .req_size, .req_wdata, .req_ready,
		.rsp_valid, .rsp_rdata, .wr_done, .address_valid_strobe, .address_ready, .bus_word_address,
		.byte_lane_enable, .write_indicator, .write_data_bus, .write_data_ready, .read_data_bus, .read_data_valid);
	eblane_target i_eblane_target (.clk, .rst, .dly, .address_valid_strobe, .bus_word_address, .byte_lane_enable,
		.write_indicator, .write_data_bus, .address_ready, .write_data_ready, .read_data_bus, .read_data_valid);
	// Counts, verdict and end of run
	task automatic give_verdict;
		$display("Compares %0d, miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One transfer; a read is compared with d
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_size <= sz;
		req_wdata <= d;
		do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 100);
		if (n >= 100) begin
			miscompares++;
			give_verdict;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		do begin @(negedge clk); n++; end while ((rsp_valid || wr_done) !== 1'b1 && n < 200);
		if (n >= 200) begin
			miscompares++;
			give_verdict;
		end
		chk({rsp_valid, wr_done}, wr ? 32'h1 : 32'h2);
		if (!wr) chk(rsp_rdata, d);
	endtask
	// Idle outputs after reset
	task automatic t_reset;
		repeat (2) @(negedge clk);
		chk({req_ready, address_valid_strobe, byte_lane_enable}, 32'h20);
	endtask
	// Byte and half lanes against a slow target
	task automatic t_lanes;
		@(posedge clk);
		dly <= 2'h3;
		xfer(1'b1, 32'hc0000010, 2'h3, 32'h0);
		for (int o = 0; o < 4; o++) xfer(1'b1, 32'hc0000010 + o, 2'h0, 32'haaaaaa10 + o);
		xfer(1'b1, 32'hc0000013, 2'h1, 32'h5555beef);
		xfer(1'b0, 32'hc0000010, 2'h2, 32'hbeef1110);
		for (int o = 0; o < 4; o++) xfer(1'b0, 32'hc0000010 + o, 2'h0, (32'hbeef1110 >> (8 * o)) & 32'hff);
		xfer(1'b0, 32'hc0000011, 2'h1, 32'h1110);
	endtask
	// Word write then word read back at the top of the address space
	task automatic t_high;
		@(posedge clk);
		dly <= 2'h0;
		xfer(1'b1, 32'hfffffffc, 2'h2, 32'h89abcdef);
		xfer(1'b0, 32'hfffffffe, 2'h2, 32'h89abcdef);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_lanes;
		t_high;
		give_verdict;
	end
endmodule // eblane_top_bench
`default_nettype wire
